/* can_rx_engine_model.sv */
// Purpose: Receive engine on the bus side that stores accepted frames
// Assumes: Driven from the bench through the put task
// Notes: Buffer index is inverted between stores so stale values show
module can_rx_engine_model (
    input wire logic aclk,
    output logic rx_store,
    output logic [4:0] rx_store_buf
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        rx_store = 1'b0;
        rx_store_buf = 5'h1F;
    end
    task automatic put(input logic [4:0] b);
        @(posedge aclk);
        rx_store <= 1'b1;
        rx_store_buf <= b;
        @(posedge aclk);
        rx_store <= 1'b0;
        rx_store_buf <= ~b;
    endtask
endmodule // can_rx_engine_model

/* can_rx_mask_flags.sv */
// Purpose: Mask registers, mask-source select for filters 8-15, receive full
//          and overflow flags, interrupt status, over an AXI4-Lite slave
// Assumes: Receive engine on aclk presents one store request per pulse
// Notes: Writes with all four byte strobes low change nothing except the interrupt enable, which they clear
//
// Local design decisions: register access over AXI4-Lite and the register offsets.
`include "can_rx_params.svh"
// Function
// - two upper extended mask bits in std register
// - sixteen lower extended mask bits include/ignore
// - mode bit selects any frame or filter type
// - store into buffer sets its full flag
// - full flags reset zero, software only clears
// - store into full buffer sets overflow flag
// - overflow flags reset zero, software clears
// - overflow flags split into two 16-bit registers
// - included bits must equal filter bits
module can_rx_mask_flags
    import can_rx_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clk_en,
    input wire logic [`ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [`ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic rx_valid,
    input wire logic [3:0] rx_filter_num,
    input wire logic [10:0] std_id_bits,
    input wire logic [17:0] ext_id_bits,
    input wire logic rx_is_ext,
    input wire logic [10:0] rx_filt_std,
    input wire logic [17:0] rx_filt_ext,
    input wire logic filter_extended_frame_select,
    output logic rx_hit,
    input wire logic rx_store,
    input wire logic [4:0] rx_store_buf,
    output logic [31:0] rx_buffer_full_flag,
    output logic [31:0] rx_buffer_overflow_flag,
    output logic irq
);
    logic [15:0] sel_high_r, sel_high_nxt;
    logic [15:0] mstd_r [3], mstd_nxt [3];
    logic [15:0] mext_r [3], mext_nxt [3];
    logic [31:0] full_r, full_nxt;
    logic [31:0] ovf_r, ovf_nxt;
    logic [`IRQ_W-1:0] ists_r, ists_nxt;
    logic [`IRQ_W-1:0] ien_r, ien_nxt;
    logic [`IRQ_W-1:0] ievt;
    wr_state_t wst_r, wst_nxt;
    logic aw_have_r, aw_have_nxt;
    logic w_have_r, w_have_nxt;
    logic [`ADDR_W-1:0] awaddr_r, awaddr_nxt;
    logic [31:0] wdata_r, wdata_nxt;
    logic [3:0] wstrb_r, wstrb_nxt;
    logic [1:0] bresp_r, bresp_nxt;
    logic rvalid_r, rvalid_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic [1:0] rresp_r, rresp_nxt;
    logic [31:0] wmask;
    logic [31:0] wbits;
    logic do_write;
    mask_sel_t sel_code;
    logic [1:0] sel_idx;
    logic [15:0] sel_std, sel_ext;
    logic [31:0] store_onehot;

    // Filters 0-7 have no mask-source select field in this block; mask 0 is always used
    always_comb begin
        sel_code = 2'h0;
        if (rx_filter_num[3]) begin
            sel_code = sel_high_r[{rx_filter_num[2:0], 1'b0} +: 2];
        end
    end

    always_comb begin
        sel_std = mstd_r[0];
        sel_ext = mext_r[0];
        sel_idx = 2'h0;
        unique case (mask_src_t'(sel_code))
            SEL_MASK0: sel_idx = 2'h0;
            SEL_MASK1: sel_idx = 2'h1;
            SEL_MASK2: sel_idx = 2'h2;
            SEL_RESERVED: sel_idx = 2'h0;
        endcase
        sel_std = mstd_r[sel_idx];
        sel_ext = mext_r[sel_idx];
    end

    can_rx_mask_match u_match (
        .std_id_bits(std_id_bits),
        .ext_id_bits(ext_id_bits),
        .msg_is_ext(rx_is_ext),
        .filt_std(rx_filt_std),
        .filt_ext(rx_filt_ext),
        .filter_extended_frame_select(filter_extended_frame_select),
        .mask_std_reg(sel_std),
        .mask_ext_reg(sel_ext),
        .hit(rx_hit)
    );

    // Write channel: address and data taken in either order
    always_comb begin
        aw_have_nxt = aw_have_r;
        w_have_nxt = w_have_r;
        awaddr_nxt = awaddr_r;
        wdata_nxt = wdata_r;
        wstrb_nxt = wstrb_r;
        wst_nxt = wst_r;
        bresp_nxt = bresp_r;
        do_write = 1'b0;
        // Readies drop while frozen so that no handshake is lost
        s_axi_awready = clk_en && (wst_r == WR_IDLE) && !aw_have_r;
        s_axi_wready = clk_en && (wst_r == WR_IDLE) && !w_have_r;
        unique case (wst_r)
            WR_IDLE: begin
                if (s_axi_awvalid && s_axi_awready) begin
                    aw_have_nxt = 1'b1;
                    awaddr_nxt = s_axi_awaddr;
                end
                if (s_axi_wvalid && s_axi_wready) begin
                    w_have_nxt = 1'b1;
                    wdata_nxt = s_axi_wdata;
                    wstrb_nxt = s_axi_wstrb;
                end
                if (aw_have_r && w_have_r) begin
                    do_write = 1'b1;
                    aw_have_nxt = 1'b0;
                    w_have_nxt = 1'b0;
                    bresp_nxt = `RESP_OKAY;
                    if (awaddr_r > `OFS_IRQ_ENABLE || awaddr_r[1:0] != 2'h0) begin
                        bresp_nxt = `RESP_SLVERR;
                    end
                    wst_nxt = WR_RESP;
                end
            end
            WR_RESP: begin
                if (s_axi_bready) begin
                    wst_nxt = WR_IDLE;
                end
            end
        endcase
    end

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            wmask[i*8 +: 8] = {8{wstrb_r[i]}};
        end
        wbits = wdata_r & wmask;
    end

    always_comb begin
        store_onehot = `RESET_ZERO32;
        if (rx_store) begin
            store_onehot[rx_store_buf] = 1'b1;
        end
    end

    always_comb begin
        sel_high_nxt = sel_high_r;
        mstd_nxt = mstd_r;
        mext_nxt = mext_r;
        full_nxt = full_r;
        ovf_nxt = ovf_r;
        ien_nxt = ien_r;
        ists_nxt = ists_r;
        if (do_write) begin
            unique case (awaddr_r)
                `OFS_MSK_SEL_HIGH: sel_high_nxt = (sel_high_r & ~wmask[15:0]) | wbits[15:0];
                `OFS_MASK0_STD: mstd_nxt[0] = (mstd_r[0] & ~(wmask[15:0] & `STD_MASK_WMASK))
                    | (wbits[15:0] & `STD_MASK_WMASK);
                `OFS_MASK0_EXT: mext_nxt[0] = (mext_r[0] & ~wmask[15:0]) | wbits[15:0];
                `OFS_MASK1_STD: mstd_nxt[1] = (mstd_r[1] & ~(wmask[15:0] & `STD_MASK_WMASK))
                    | (wbits[15:0] & `STD_MASK_WMASK);
                `OFS_MASK1_EXT: mext_nxt[1] = (mext_r[1] & ~wmask[15:0]) | wbits[15:0];
                `OFS_MASK2_STD: mstd_nxt[2] = (mstd_r[2] & ~(wmask[15:0] & `STD_MASK_WMASK))
                    | (wbits[15:0] & `STD_MASK_WMASK);
                `OFS_MASK2_EXT: mext_nxt[2] = (mext_r[2] & ~wmask[15:0]) | wbits[15:0];
                // Written zeros clear, written ones are ignored
                `OFS_FULL_LOW: full_nxt[15:0] = full_r[15:0] & (wdata_r[15:0] | ~wmask[15:0]);
                `OFS_FULL_HIGH: full_nxt[31:16] = full_r[31:16] & (wdata_r[15:0] | ~wmask[15:0]);
                `OFS_OVF_LOW: ovf_nxt[15:0] = ovf_r[15:0] & (wdata_r[15:0] | ~wmask[15:0]);
                `OFS_OVF_HIGH: ovf_nxt[31:16] = ovf_r[31:16] & (wdata_r[15:0] | ~wmask[15:0]);
                `OFS_IRQ_CLEAR: ists_nxt = ists_r & ~wbits[`IRQ_W-1:0];
                `OFS_IRQ_ENABLE: ien_nxt = wbits[`IRQ_W-1:0];
                default: ;
            endcase
        end
        // Hardware set wins over a software clear in the same cycle
        ovf_nxt = ovf_nxt | (store_onehot & full_r);
        full_nxt = full_nxt | store_onehot;
        ists_nxt = ists_nxt | ievt;
    end

    always_comb begin
        ievt = '0;
        ievt[`IRQ_WRITE_BIT] = rx_store;
        ievt[`IRQ_OVF_BIT] = |(store_onehot & full_r);
        ievt[`IRQ_NOMATCH_BIT] = rx_valid && !rx_hit;
    end

    // Read channel: one read at a time, answer one cycle after acceptance
    always_comb begin
        rvalid_nxt = rvalid_r;
        rdata_nxt = rdata_r;
        rresp_nxt = rresp_r;
        // A frozen block takes no read address
        s_axi_arready = clk_en && !rvalid_r;
        if (rvalid_r && s_axi_rready) begin
            rvalid_nxt = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_nxt = 1'b1;
            rresp_nxt = `RESP_OKAY;
            rdata_nxt = `RESET_ZERO32;
            unique case (s_axi_araddr)
                `OFS_MSK_SEL_HIGH: rdata_nxt[15:0] = sel_high_r;
                `OFS_MASK0_STD: rdata_nxt[15:0] = mstd_r[0];
                `OFS_MASK0_EXT: rdata_nxt[15:0] = mext_r[0];
                `OFS_MASK1_STD: rdata_nxt[15:0] = mstd_r[1];
                `OFS_MASK1_EXT: rdata_nxt[15:0] = mext_r[1];
                `OFS_MASK2_STD: rdata_nxt[15:0] = mstd_r[2];
                `OFS_MASK2_EXT: rdata_nxt[15:0] = mext_r[2];
                `OFS_FULL_LOW: rdata_nxt[15:0] = full_r[15:0];
                `OFS_FULL_HIGH: rdata_nxt[15:0] = full_r[31:16];
                `OFS_OVF_LOW: rdata_nxt[15:0] = ovf_r[15:0];
                `OFS_OVF_HIGH: rdata_nxt[15:0] = ovf_r[31:16];
                `OFS_IRQ_STATUS: rdata_nxt[`IRQ_W-1:0] = ists_r;
                `OFS_IRQ_CLEAR: rdata_nxt = `RESET_ZERO32;
                `OFS_IRQ_ENABLE: rdata_nxt[`IRQ_W-1:0] = ien_r;
                default: rresp_nxt = `RESP_SLVERR;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sel_high_r <= `RESET_ZERO16;
            for (int i = 0; i < 3; i++) begin
                mstd_r[i] <= `RESET_ZERO16;
                mext_r[i] <= `RESET_ZERO16;
            end
            full_r <= `RESET_ZERO32;
            ovf_r <= `RESET_ZERO32;
            ists_r <= '0;
            ien_r <= '0;
            wst_r <= WR_IDLE;
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            awaddr_r <= '0;
            wdata_r <= `RESET_ZERO32;
            wstrb_r <= 4'h0;
            bresp_r <= `RESP_OKAY;
            rvalid_r <= 1'b0;
            rdata_r <= `RESET_ZERO32;
            rresp_r <= `RESP_OKAY;
        end else if (clk_en) begin
            sel_high_r <= sel_high_nxt;
            mstd_r <= mstd_nxt;
            mext_r <= mext_nxt;
            full_r <= full_nxt;
            ovf_r <= ovf_nxt;
            ists_r <= ists_nxt;
            ien_r <= ien_nxt;
            wst_r <= wst_nxt;
            aw_have_r <= aw_have_nxt;
            w_have_r <= w_have_nxt;
            awaddr_r <= awaddr_nxt;
            wdata_r <= wdata_nxt;
            wstrb_r <= wstrb_nxt;
            bresp_r <= bresp_nxt;
            rvalid_r <= rvalid_nxt;
            rdata_r <= rdata_nxt;
            rresp_r <= rresp_nxt;
        end
    end

    assign s_axi_bvalid = (wst_r == WR_RESP);
    assign s_axi_bresp = bresp_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;
    assign rx_buffer_full_flag = full_r;
    assign rx_buffer_overflow_flag = ovf_r;
    assign irq = |(ists_r & ien_r);
endmodule // can_rx_mask_flags

/* can_rx_mask_flags_properties.sv */
// Purpose: Port checks for the receive mask and flag block
// Assumes: One aclk domain, synchronous active-low reset
// Notes: Bound to every instance of the block
module can_rx_mask_flags_properties (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clk_en,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic s_axi_bvalid,
    input wire logic [10:0] std_id_bits,
    input wire logic [17:0] ext_id_bits,
    input wire logic rx_is_ext,
    input wire logic [10:0] rx_filt_std,
    input wire logic [17:0] rx_filt_ext,
    input wire logic filter_extended_frame_select,
    input wire logic rx_hit,
    input wire logic rx_store,
    input wire logic [4:0] rx_store_buf,
    input wire logic [31:0] rx_buffer_full_flag,
    input wire logic [31:0] rx_buffer_overflow_flag
);
    timeunit 1ns;
    timeprecision 100ps;
    logic st;
    logic ovf_cause;
    logic same_id;
    assign st = clk_en && rx_store;
    assign ovf_cause = st && rx_buffer_full_flag[rx_store_buf];
    // Identical identifier and frame type passes whatever the masks hold
    assign same_id = std_id_bits == rx_filt_std
        && (!rx_is_ext || ext_id_bits == rx_filt_ext)
        && rx_is_ext == filter_extended_frame_select;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_full_set; st |=> rx_buffer_full_flag[$past(rx_store_buf)]; endproperty
    a_full_set: assert property (p_full_set) else $error("store left full flag clear");
    property p_ovf_set; ovf_cause |=> rx_buffer_overflow_flag[$past(rx_store_buf)]; endproperty
    a_ovf_set: assert property (p_ovf_set) else $error("overflow flag not set");
    property p_full_rise; |(rx_buffer_full_flag & ~$past(rx_buffer_full_flag)) |-> $past(st);
    endproperty
    a_full_rise: assert property (p_full_rise) else $error("full flag set without store");
    property p_ovf_rise;
        |(rx_buffer_overflow_flag & ~$past(rx_buffer_overflow_flag)) |-> $past(ovf_cause);
    endproperty
    a_ovf_rise: assert property (p_ovf_rise) else $error("overflow set without cause");
    property p_full_fall; |($past(rx_buffer_full_flag) & ~rx_buffer_full_flag) |-> $rose(s_axi_bvalid);
    endproperty
    a_full_fall: assert property (p_full_fall) else $error("full flag fell without write");
    property p_ovf_fall;
        |($past(rx_buffer_overflow_flag) & ~rx_buffer_overflow_flag) |-> $rose(s_axi_bvalid);
    endproperty
    a_ovf_fall: assert property (p_ovf_fall) else $error("overflow fell without write");
    property p_read_answer; s_axi_arvalid && s_axi_arready && clk_en |=> s_axi_rvalid; endproperty
    a_read_answer: assert property (p_read_answer) else $error("read not answered");
    property p_read_done; s_axi_rvalid && s_axi_rready && clk_en |=> !s_axi_rvalid; endproperty
    a_read_done: assert property (p_read_done) else $error("read answered twice");
    property p_exact_hit; same_id |-> rx_hit; endproperty
    a_exact_hit: assert property (p_exact_hit) else $error("exact identifier rejected");
endmodule // can_rx_mask_flags_properties
bind can_rx_mask_flags can_rx_mask_flags_properties chk_u (
    .aclk(aclk),
    .aresetn(aresetn),
    .clk_en(clk_en),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .s_axi_bvalid(s_axi_bvalid),
    .std_id_bits(std_id_bits),
    .ext_id_bits(ext_id_bits),
    .rx_is_ext(rx_is_ext),
    .rx_filt_std(rx_filt_std),
    .rx_filt_ext(rx_filt_ext),
    .filter_extended_frame_select(filter_extended_frame_select),
    .rx_hit(rx_hit),
    .rx_store(rx_store),
    .rx_store_buf(rx_store_buf),
    .rx_buffer_full_flag(rx_buffer_full_flag),
    .rx_buffer_overflow_flag(rx_buffer_overflow_flag)
);

/* can_rx_mask_flags_tb.sv */
// Purpose: Self-checking bench for the receive mask and flag block
// Assumes: 40 MHz aclk, AXI4-Lite master tasks, engine model for stores
// Notes: Filter extended bits stay zero; the message side holds them at 18'h3FFFE
`include "can_rx_params.svh"
module can_rx_mask_flags_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic aclk, aresetn, clk_en, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic rx_valid, rx_is_ext, filter_extended_frame_select, rx_hit, rx_store, irq;
    logic [`ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rx_buffer_full_flag, rx_buffer_overflow_flag;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [3:0] s_axi_wstrb, rx_filter_num;
    logic [4:0] rx_store_buf;
    logic [10:0] std_id_bits, rx_filt_std;
    logic [17:0] ext_id_bits, rx_filt_ext;
    int n_errors = 0;
    int compares = 0;
    // Rows: offset, value written, filter, identifier, {ext frame, filter ext}, expected hit
    logic [39:0] steps [15] = '{
        {`OFS_MASK0_STD, 16'hFFE0, 4'h0, 11'h123, 3'b001},
        {`OFS_MASK0_STD, 16'hFFE0, 4'h0, 11'h122, 3'b100},
        {`OFS_MASK0_STD, 16'hFFC0, 4'h0, 11'h122, 3'b101},
        {`OFS_MASK0_STD, 16'hFFC8, 4'h0, 11'h122, 3'b100},
        {`OFS_MASK0_STD, 16'hFFC8, 4'h0, 11'h122, 3'b001},
        {`OFS_MASK0_STD, 16'hFFC1, 4'h0, 11'h122, 3'b100},
        {`OFS_MASK0_STD, 16'hFFC0, 4'h0, 11'h122, 3'b101},
        {`OFS_MASK0_EXT, 16'h0002, 4'h0, 11'h122, 3'b100},
        {`OFS_MASK0_EXT, 16'h0001, 4'h0, 11'h122, 3'b101},
        {`OFS_MSK_SEL_HIGH, 16'h0001, 4'h8, 11'h000, 3'b101},
        {`OFS_MSK_SEL_HIGH, 16'h0001, 4'h7, 11'h000, 3'b100},
        {`OFS_MASK2_STD, 16'hFFE0, 4'h8, 11'h000, 3'b101},
        {`OFS_MSK_SEL_HIGH, 16'h0008, 4'h9, 11'h000, 3'b100},
        {`OFS_MSK_SEL_HIGH, 16'h0008, 4'h8, 11'h000, 3'b100},
        {`OFS_MSK_SEL_HIGH, 16'h000C, 4'h9, 11'h000, 3'b100}
    };
    logic [5:0] zero_ofs [5] = '{`OFS_FULL_LOW, `OFS_FULL_HIGH, `OFS_OVF_LOW, `OFS_OVF_HIGH,
        `OFS_MSK_SEL_HIGH};
    can_rx_mask_flags dut_u (
        .aclk(aclk),
        .aresetn(aresetn),
        .clk_en(clk_en),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .rx_valid(rx_valid),
        .rx_filter_num(rx_filter_num),
        .std_id_bits(std_id_bits),
        .ext_id_bits(ext_id_bits),
        .rx_is_ext(rx_is_ext),
        .rx_filt_std(rx_filt_std),
        .rx_filt_ext(rx_filt_ext),
        .filter_extended_frame_select(filter_extended_frame_select),
        .rx_hit(rx_hit),
        .rx_store(rx_store),
        .rx_store_buf(rx_store_buf),
        .rx_buffer_full_flag(rx_buffer_full_flag),
        .rx_buffer_overflow_flag(rx_buffer_overflow_flag),
        .irq(irq)
    );
    can_rx_engine_model eng_u (
        .aclk(aclk),
        .rx_store(rx_store),
        .rx_store_buf(rx_store_buf)
    );
    initial begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        logic [1:0] p, t, r;
        logic hb;
        p = 2'b11;
        hb = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= {16'h0000, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
        while (!hb) begin
            @(negedge aclk);
            hb = s_axi_bvalid;
            r = s_axi_bresp;
            t = p & {s_axi_awready, s_axi_wready};
            p = p & ~t;
            @(posedge aclk);
            if (t[1]) s_axi_awvalid <= 1'b0;
            if (t[0]) s_axi_wvalid <= 1'b0;
        end
        chk({30'h0, r}, 32'h0);
    endtask
    task automatic rd(input logic [5:0] a, input logic [15:0] e, input logic [1:0] er = 2'h0);
        logic p, t, hr;
        logic [33:0] got;
        p = 1'b1;
        hr = 1'b0;
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'b11;
        while (!hr) begin
            @(negedge aclk);
            hr = !p && s_axi_rvalid;
            got = {s_axi_rresp, s_axi_rdata};
            t = p && s_axi_arready;
            p = p && !t;
            @(posedge aclk);
            if (t) s_axi_arvalid <= 1'b0;
        end
        chk(got[31:0], {16'h0000, e});
        chk({30'h0, got[33:32]}, {30'h0, er});
    endtask
    task automatic report_and_stop();
        $display("mismatches %0d comparisons %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        #100000;
        n_errors++;
        report_and_stop();
    end
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 5'h00;
        {s_axi_rready, rx_valid, rx_is_ext, filter_extended_frame_select} = 4'h0;
        {clk_en, s_axi_wstrb} = 5'h1F;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, rx_filter_num, std_id_bits} = 59'h0;
        {rx_filt_std, rx_filt_ext, ext_id_bits} = {11'h123, 18'h00000, 18'h3FFFE};
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        foreach (zero_ofs[i]) rd(zero_ofs[i], 16'h0000);
        rd(6'h3C, 16'h0000, `RESP_SLVERR);
        eng_u.put(5'd3);
        eng_u.put(5'd19);
        @(negedge aclk);
        chk(rx_buffer_full_flag, 32'h0008_0008);
        @(posedge aclk);
        rd(`OFS_FULL_LOW, 16'h0008);
        rd(`OFS_FULL_HIGH, 16'h0008);
        eng_u.put(5'd3);
        eng_u.put(5'd19);
        @(negedge aclk);
        chk(rx_buffer_overflow_flag, 32'h0008_0008);
        @(posedge aclk);
        rd(`OFS_OVF_LOW, 16'h0008);
        rd(`OFS_OVF_HIGH, 16'h0008);
        wr(`OFS_FULL_LOW, 16'hFFFF);
        rd(`OFS_FULL_LOW, 16'h0008);
        wr(`OFS_FULL_LOW, 16'hFFF7);
        rd(`OFS_FULL_LOW, 16'h0000);
        wr(`OFS_OVF_HIGH, 16'hFFF7);
        rd(`OFS_OVF_HIGH, 16'h0000);
        rd(`OFS_OVF_LOW, 16'h0008);
        clk_en <= 1'b0;
        eng_u.put(5'd7);
        @(negedge aclk);
        chk(rx_buffer_full_flag, 32'h0008_0000);
        @(posedge aclk);
        clk_en <= 1'b1;
        wr(`OFS_MASK0_STD, 16'hFFFF);
        rd(`OFS_MASK0_STD, 16'hFFEB);
        foreach (steps[i]) begin
            wr(steps[i][39:34], steps[i][33:18]);
            rx_filter_num <= steps[i][17:14];
            std_id_bits <= steps[i][13:3];
            {rx_is_ext, filter_extended_frame_select} <= steps[i][2:1];
            @(negedge aclk);
            chk({31'h0, rx_hit}, {31'h0, steps[i][0]});
            @(posedge aclk);
        end
        rd(`OFS_MSK_SEL_HIGH, 16'h000C);
        wr(`OFS_IRQ_CLEAR, 16'h0007);
        rd(`OFS_IRQ_STATUS, 16'h0000);
        wr(`OFS_IRQ_ENABLE, 16'h0001);
        eng_u.put(5'd5);
        @(negedge aclk);
        chk({31'h0, irq}, 32'h1);
        @(posedge aclk);
        wr(`OFS_IRQ_CLEAR, 16'h0001);
        @(negedge aclk);
        chk({31'h0, irq}, 32'h0);
        @(posedge aclk);
        rx_valid <= 1'b1;
        @(posedge aclk);
        rx_valid <= 1'b0;
        rd(`OFS_IRQ_STATUS, 16'h0004);
        wr(`OFS_IRQ_ENABLE, 16'h0004);
        @(negedge aclk);
        chk({31'h0, irq}, 32'h1);
        report_and_stop();
    end
endmodule // can_rx_mask_flags_tb

/* can_rx_mask_match.sv */
// Purpose: Acceptance compare of one received identifier against one filter
// Assumes: Mask fields already chosen by the caller
// Notes: Purely combinational
`include "can_rx_params.svh"
module can_rx_mask_match
    import can_rx_pkg::*;
(
    input wire logic [10:0] std_id_bits,
    input wire logic [17:0] ext_id_bits,
    input wire logic msg_is_ext,
    input wire logic [10:0] filt_std,
    input wire logic [17:0] filt_ext,
    input wire logic filter_extended_frame_select,
    input wire logic [15:0] mask_std_reg,
    input wire logic [15:0] mask_ext_reg,
    output logic hit
);
    logic [10:0] std_use;
    logic [17:0] ext_use;
    logic id_type_match_mode;
    logic std_ok;
    logic ext_ok;
    logic type_ok;

    always_comb begin
        std_use = mask_std_reg[`STD_MASK_MSB:`STD_MASK_LSB];
        ext_use = {mask_std_reg[`EXT_HI_MSB:`EXT_HI_LSB], mask_ext_reg};
        id_type_match_mode = mask_std_reg[`ID_TYPE_MATCH_MODE_BIT];
        std_ok = ((std_id_bits ^ filt_std) & std_use) == 11'h000;
        // Extended bits only exist in extended frames
        ext_ok = !msg_is_ext || (((ext_id_bits ^ filt_ext) & ext_use) == 18'h00000);
        type_ok = !id_type_match_mode || (msg_is_ext == filter_extended_frame_select);
        hit = std_ok && ext_ok && type_ok;
    end
endmodule // can_rx_mask_match

/* can_rx_params.svh */
// Purpose: Offsets, field positions and reset values of the receive mask block
// Assumes: Included by the design files and the bench
// Notes: Byte addresses on an AXI4-Lite bus, one 32-bit word per register
`ifndef CAN_RX_PARAMS_SVH
`define CAN_RX_PARAMS_SVH
`define ADDR_W 6
`define OFS_MSK_SEL_HIGH 6'h00
`define OFS_MASK0_STD 6'h04
`define OFS_MASK0_EXT 6'h08
`define OFS_MASK1_STD 6'h0C
`define OFS_MASK1_EXT 6'h10
`define OFS_MASK2_STD 6'h14
`define OFS_MASK2_EXT 6'h18
`define OFS_FULL_LOW 6'h1C
`define OFS_FULL_HIGH 6'h20
`define OFS_OVF_LOW 6'h24
`define OFS_OVF_HIGH 6'h28
`define OFS_IRQ_STATUS 6'h2C
`define OFS_IRQ_CLEAR 6'h30
`define OFS_IRQ_ENABLE 6'h34
`define STD_MASK_LSB 5
`define STD_MASK_MSB 15
`define ID_TYPE_MATCH_MODE_BIT 3
`define EXT_HI_MSB 1
`define EXT_HI_LSB 0
`define STD_MASK_WMASK 16'hFFEB
`define RESET_ZERO16 16'h0000
`define RESET_ZERO32 32'h0000_0000
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define IRQ_WRITE_BIT 0
`define IRQ_OVF_BIT 1
`define IRQ_NOMATCH_BIT 2
`define IRQ_W 3
`endif

/* can_rx_pkg.sv */
// Purpose: Types shared by the receive mask block
// Assumes: can_rx_params.svh holds the numbers
// Notes: Types only
package can_rx_pkg;
    typedef logic [1:0] mask_sel_t;
    typedef enum logic [1:0] {
        SEL_MASK0,
        SEL_MASK1,
        SEL_MASK2,
        SEL_RESERVED
    } mask_src_t;
    typedef enum {
        WR_IDLE,
        WR_RESP
    } wr_state_t;
endpackage
